// ==== src/cltd_consts.svh ====
// Constants for the control and literal instruction decoder.
// Assumes it is included by bare name from the core.
`ifndef CLTD_CONSTS_SVH
`define CLTD_CONSTS_SVH

// Register indices on the plain register port.
`define CLTD_REG_CTRL   4'h0
`define CLTD_REG_STATUS 4'h1
`define CLTD_REG_WORK   4'h2
`define CLTD_REG_PC     4'h3
`define CLTD_REG_TPTR   4'h4
`define CLTD_REG_TLAT   4'h5
`define CLTD_REG_PROD   4'h6
`define CLTD_REG_PTR0   4'h7
`define CLTD_REG_PTR1   4'h8
`define CLTD_REG_PTR2   4'h9

// Control register field positions and reset value.
`define CLTD_CTRL_RUN  0
`define CLTD_CTRL_GIE  1
`define CLTD_CTRL_PEIE 2
`define CLTD_CTRL_RST  3'h0

// Reset values of the working state.
`define CLTD_W_RST    8'h00
`define CLTD_PC_RST   20'h00000
`define CLTD_FLAG_RST 5'h00

// Return stack size.
`define CLTD_STACK_DEPTH 31
`define CLTD_SP_FULL     5'h1f

// Top nibbles of instruction groups.
`define CLTD_HI_LIT    4'h0
`define CLTD_HI_REL    4'hd
`define CLTD_HI_BRANCH 4'he
`define CLTD_HI_WORD2  4'hf

// Second nibbles of literal operations and of the two-word branch-group words.
`define CLTD_N2_SUB  4'h8
`define CLTD_N2_IOR  4'h9
`define CLTD_N2_XOR  4'ha
`define CLTD_N2_AND  4'hb
`define CLTD_N2_RETL 4'hc
`define CLTD_N2_MUL  4'hd
`define CLTD_N2_MOV  4'he
`define CLTD_N2_ADD  4'hf
`define CLTD_N2_PTR  4'he
`define CLTD_N2_JMP  4'hf

// Single-word control opcodes.
`define CLTD_OP_SLEEP  16'h0003
`define CLTD_OP_WDCLR  16'h0004
`define CLTD_OP_PUSH   16'h0005
`define CLTD_OP_POP    16'h0006
`define CLTD_OP_DAW    16'h0007
`define CLTD_OP_SWRST  16'h00ff
`define CLTD_OP_IRET   15'h0008
`define CLTD_OP_RET    15'h0009
`define CLTD_OP_PROGRAM_MEMORY_READ  14'h0002
`define CLTD_OP_PROGRAM_MEMORY_WRITE  14'h0003
`define CLTD_OP_BANK   12'h010

`endif

// ==== src/cltd_pkg.sv ====
// Types shared by the control and literal instruction decoder.
// Assumes the constants header sits beside it.
package cltd_pkg;
  typedef enum logic [3:0] {
    ST_EXEC  = 4'h1,
    ST_WORD2 = 4'h2,
    ST_FLUSH = 4'h4,
    ST_SLEEP = 4'h8
  } cltd_state_e;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_ADD  = 3'h1,
    ALU_SUB  = 3'h2,
    ALU_AND  = 3'h3,
    ALU_OR   = 3'h4,
    ALU_XOR  = 3'h5,
    ALU_DAW  = 3'h6
  } cltd_alu_e;

  typedef logic [19:0] cltd_pc_t;
endpackage

// ==== src/cltd_alu.sv ====
// Eight-bit literal arithmetic and logic unit with flag results.
// Assumes the caller decides which flags it actually writes back.
`timescale 1ns/1ps
module cltd_alu (
  input  wire cltd_pkg::cltd_alu_e op,     // Operation select.
  input  wire logic [7:0]          wIn,    // Working register value.
  input  wire logic [7:0]          litIn,  // Literal from the word.
  input  wire logic                cIn,    // Current carry flag.
  input  wire logic                dcIn,   // Current half-carry flag.
  output logic      [7:0]          result, // Operation result.
  output logic                     cOut,   // Carry result.
  output logic                     dcOut,  // Half-carry result.
  output logic                     zOut,   // Zero result.
  output logic                     ovOut,  // Signed overflow result.
  output logic                     nOut    // Negative result.
);
  logic [8:0] sumFull;
  logic [4:0] sumHalf;
  logic [8:0] difFull;
  logic [4:0] difHalf;
  logic [8:0] dawLow;
  logic [8:0] dawHigh;
  logic       lowFix;
  logic       highFix;

  // Subtraction is literal minus working register; carry means no borrow.
  assign sumFull = {1'b0, litIn} + {1'b0, wIn};
  assign sumHalf = {1'b0, litIn[3:0]} + {1'b0, wIn[3:0]};
  assign difFull = {1'b0, litIn} + {1'b0, ~wIn} + 9'h001;
  assign difHalf = {1'b0, litIn[3:0]} + {1'b0, ~wIn[3:0]} + 5'h01;

  // Decimal correction fixes each nibble that left the range 0 to 9.
  assign lowFix  = (wIn[3:0] > 4'h9) || dcIn;
  assign dawLow  = {1'b0, wIn} + (lowFix ? 9'h006 : 9'h000);
  assign highFix = (dawLow[7:4] > 4'h9) || cIn || dawLow[8];
  assign dawHigh = dawLow + (highFix ? 9'h060 : 9'h000);

  // Result and flag selection per operation.
  always_comb begin
    result = litIn;
    cOut   = cIn;
    dcOut  = dcIn;
    ovOut  = 1'b0;
    case (op)
      cltd_pkg::ALU_ADD: begin
        result = sumFull[7:0];
        cOut   = sumFull[8];
        dcOut  = sumHalf[4];
        ovOut  = (litIn[7] == wIn[7]) && (sumFull[7] != litIn[7]);
      end
      cltd_pkg::ALU_SUB: begin
        result = difFull[7:0];
        cOut   = difFull[8];
        dcOut  = difHalf[4];
        ovOut  = (litIn[7] != wIn[7]) && (difFull[7] != litIn[7]);
      end
      cltd_pkg::ALU_AND: result = litIn & wIn;
      cltd_pkg::ALU_OR:  result = litIn | wIn;
      cltd_pkg::ALU_XOR: result = litIn ^ wIn;
      cltd_pkg::ALU_DAW: begin
        result = dawHigh[7:0];
        cOut   = highFix;
      end
      default: result = litIn;
    endcase
  end

  assign zOut = (result == 8'h00);
  assign nOut = result[7];
endmodule

// ==== src/cltd_core.sv ====
// Control-flow, literal and table-access instruction execution core.
// Assumes an asynchronous program memory answering progWord for progAddr
// in the same cycle, and a table memory on the same clock.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cltd_consts.svh"

module cltd_core (
  input  wire logic        core_clk,   // Instruction-cycle clock.
  input  wire logic        reset,      // Synchronous reset, high.
  output logic [19:0]      progAddr,   // Program word address.
  input  wire logic [15:0] progWord,   // Word at progAddr.
  output logic [20:0]      tblAddr,    // Table byte address.
  output logic             tblRdStb,   // Table read strobe.
  input  wire logic [7:0]  tblRdData,  // Read data while strobed.
  output logic             tblWrReq,   // Table write in progress.
  output logic [7:0]       tblWrData,  // Table write data.
  input  wire logic        tblWrDone,  // Write finished pulse.
  input  wire logic        wakeEvt,    // Wake from standby.
  output logic             wdtClear,   // Watchdog clear pulse.
  output logic             sleepMode,  // Standby indicator.
  output logic             softReset,  // Software reset pulse.
  output logic             gieOut,     // Global interrupt enable.
  output logic             peieOut,    // Peripheral interrupt enable.
  input  wire logic [3:0]  regAddr,    // Register index.
  input  wire logic [31:0] regWrData,  // Register write data.
  input  wire logic        regWrStb,   // Register write strobe.
  input  wire logic        regRdStb,   // Register read strobe.
  output logic [31:0]      regRdData   // Read data, next cycle.
);
  cltd_pkg::cltd_state_e state_ff, nxt_state;
  cltd_pkg::cltd_pc_t    pc_ff, nxt_pc, pcNext, brTarget, relTarget;
  cltd_pkg::cltd_pc_t    stack_ff [0:`CLTD_STACK_DEPTH-1];
  cltd_pkg::cltd_pc_t    stackTop, stkVal;
  cltd_pkg::cltd_alu_e   aluOp;
  logic [4:0]  sp_ff, nxt_sp;
  logic [7:0]  w_ff, nxt_w, aluRes, lit;
  logic [3:0]  bsr_ff, nxt_bsr, hi, n2;
  logic [4:0]  flags_ff, nxt_flags, aluFlags;
  logic [14:0] shadow_ff;
  logic        to_ff, nxt_to, pd_ff, nxt_pd;
  logic        run_ff, nxt_run, gie_ff, nxt_gie, peie_ff, nxt_peie;
  logic [15:0] word1_ff, nxt_word1, prod_ff, nxt_prod;
  logic [20:0] tptr_ff, nxt_tptr, tptrInc, tptrDec, nxt_taddr;
  logic [7:0]  tlat_ff, nxt_tlat, nxt_twdata;
  logic [11:0] ptr_ff [0:2];
  logic [11:0] nxt_ptr [0:2];
  logic        nxt_trd, nxt_twr, nxt_wdt, nxt_soft;
  logic        stkPush, stkPop, shadowSave, coreReset, tblBusy;
  logic        isBranch, condMet, isRelJmp, isRcall, isLong, isIret;
  logic        isRet, isRetl, isAlu, isLogic, isMov, isMul, isBank;
  logic        isTblRd, isTblWt, isDaw;
  logic [31:0] rdMux;

  // Field extraction and decode of the word at the program counter.
  assign hi       = progWord[15:12];
  assign n2       = progWord[11:8];
  assign lit      = progWord[7:0];
  assign pcNext   = pc_ff + 20'h00001;
  assign brTarget = pcNext + {{12{lit[7]}}, lit};
  assign relTarget = pcNext + {{9{progWord[10]}}, progWord[10:0]};
  assign isBranch = (hi == `CLTD_HI_BRANCH) && !progWord[11];
  assign isRelJmp = (hi == `CLTD_HI_REL) && !progWord[11];
  assign isRcall  = (hi == `CLTD_HI_REL) && progWord[11];
  assign isLong   = (hi == `CLTD_HI_BRANCH) && (n2[3:1] == 3'h6 ||
                    n2 == `CLTD_N2_JMP || (n2 == `CLTD_N2_PTR &&
                    progWord[7:6] == 2'h0));
  assign isIret   = progWord[15:1] == `CLTD_OP_IRET;
  assign isRet    = progWord[15:1] == `CLTD_OP_RET;
  assign isRetl   = (hi == `CLTD_HI_LIT) && (n2 == `CLTD_N2_RETL);
  assign isMov    = (hi == `CLTD_HI_LIT) && (n2 == `CLTD_N2_MOV);
  assign isMul    = (hi == `CLTD_HI_LIT) && (n2 == `CLTD_N2_MUL);
  assign isBank   = progWord[15:4] == `CLTD_OP_BANK;
  assign isDaw    = progWord == `CLTD_OP_DAW;
  assign isTblRd  = progWord[15:2] == `CLTD_OP_PROGRAM_MEMORY_READ;
  assign isTblWt  = progWord[15:2] == `CLTD_OP_PROGRAM_MEMORY_WRITE;
  assign isLogic  = (hi == `CLTD_HI_LIT) && (n2 == `CLTD_N2_AND ||
                    n2 == `CLTD_N2_IOR || n2 == `CLTD_N2_XOR);
  assign isAlu    = isLogic || isDaw || ((hi == `CLTD_HI_LIT) &&
                    (n2 == `CLTD_N2_ADD || n2 == `CLTD_N2_SUB));

  // Condition code: bits 2:1 pick zero, carry, overflow, negative;
  // bit 0 inverts the test. Flags are packed {n, ov, z, dc, c}.
  assign condMet = progWord[8] ^ (progWord[10:9] == 2'h0 ? flags_ff[2] :
                   progWord[10:9] == 2'h1 ? flags_ff[0] :
                   progWord[10:9] == 2'h2 ? flags_ff[3] :
                   flags_ff[4]);

  // Operation select for the literal unit.
  assign aluOp = isDaw ? cltd_pkg::ALU_DAW :
                 n2 == `CLTD_N2_ADD ? cltd_pkg::ALU_ADD :
                 n2 == `CLTD_N2_SUB ? cltd_pkg::ALU_SUB :
                 n2 == `CLTD_N2_AND ? cltd_pkg::ALU_AND :
                 n2 == `CLTD_N2_IOR ? cltd_pkg::ALU_OR :
                 n2 == `CLTD_N2_XOR ? cltd_pkg::ALU_XOR :
                 cltd_pkg::ALU_PASS;

  cltd_alu u_alu (
    .op     (aluOp),
    .wIn    (w_ff),
    .litIn  (isDaw ? w_ff : lit),
    .cIn    (flags_ff[0]),
    .dcIn   (flags_ff[1]),
    .result (aluRes),
    .cOut   (aluFlags[0]),
    .dcOut  (aluFlags[1]),
    .zOut   (aluFlags[2]),
    .ovOut  (aluFlags[3]),
    .nOut   (aluFlags[4])
  );

  // Stack top, table pointer arithmetic and the shared-resource guard.
  // Table ops stall while a write runs so its address is never disturbed.
  assign stackTop  = stack_ff[(sp_ff == 5'h00) ? 5'h00 : sp_ff - 5'h01];
  assign tptrInc   = tptr_ff + 21'h000001;
  assign tptrDec   = tptr_ff - 21'h000001;
  assign tblBusy   = tblWrReq && !tblWrDone;
  assign coreReset = reset || softReset;

  // Next-state logic for instruction execution and register writes.
  always_comb begin
    nxt_state  = state_ff;
    nxt_pc     = pc_ff;
    nxt_w      = w_ff;
    nxt_bsr    = bsr_ff;
    nxt_flags  = flags_ff;
    nxt_to     = to_ff;
    nxt_pd     = pd_ff;
    nxt_run    = run_ff;
    nxt_gie    = gie_ff;
    nxt_peie   = peie_ff;
    nxt_word1  = word1_ff;
    nxt_prod   = prod_ff;
    nxt_tptr   = tptr_ff;
    nxt_tlat   = tlat_ff;
    nxt_ptr    = ptr_ff;
    nxt_sp     = sp_ff;
    nxt_taddr  = tblAddr;
    nxt_twdata = tblWrData;
    nxt_trd    = 1'b0;
    nxt_twr    = tblBusy;
    nxt_wdt    = 1'b0;
    nxt_soft   = 1'b0;
    stkPush    = 1'b0;
    stkPop     = 1'b0;
    stkVal     = pcNext;
    shadowSave = 1'b0;
    case (state_ff)
      cltd_pkg::ST_EXEC: begin
        if (run_ff && !((isTblRd || isTblWt) && tblBusy)) begin
          nxt_pc = pcNext;
          if (isBranch) begin
            if (condMet) begin
              nxt_pc    = brTarget;
              nxt_state = cltd_pkg::ST_FLUSH;
            end
          end else if (isRelJmp || isRcall) begin
            nxt_pc    = relTarget;
            stkPush   = isRcall;
            nxt_state = cltd_pkg::ST_FLUSH;
          end else if (isLong) begin
            nxt_word1 = progWord;
            nxt_state = cltd_pkg::ST_WORD2;
          end else if (isIret || isRet || isRetl) begin
            nxt_pc    = stackTop;
            stkPop    = 1'b1;
            nxt_state = cltd_pkg::ST_FLUSH;
            if (isIret) begin
              nxt_gie  = 1'b1;
              nxt_peie = 1'b1;
            end
            if (isRetl) begin
              nxt_w = lit;
            end else if (progWord[0]) begin
              nxt_w     = shadow_ff[7:0];
              nxt_bsr   = shadow_ff[11:8];
              nxt_flags = {shadow_ff[14:12], nxt_flags[1:0]};
            end
          end else if (isAlu) begin
            nxt_w = aluRes;
            if (isDaw) begin
              nxt_flags[0] = aluFlags[0];
            end else if (isLogic) begin
              nxt_flags[2] = aluFlags[2];
              nxt_flags[4] = aluFlags[4];
            end else begin
              nxt_flags = aluFlags;
            end
          end else if (isMov) begin
            nxt_w = lit;
          end else if (isMul) begin
            nxt_prod = 16'(lit) * 16'(w_ff);
          end else if (isBank) begin
            nxt_bsr = lit[3:0];
          end else if (progWord == `CLTD_OP_PUSH) begin
            stkPush = 1'b1;
          end else if (progWord == `CLTD_OP_POP) begin
            stkPop = 1'b1;
          end else if (progWord == `CLTD_OP_SLEEP) begin
            nxt_to    = 1'b1;
            nxt_pd    = 1'b0;
            nxt_wdt   = 1'b1;
            nxt_state = cltd_pkg::ST_SLEEP;
          end else if (progWord == `CLTD_OP_WDCLR) begin
            nxt_to  = 1'b1;
            nxt_pd  = 1'b1;
            nxt_wdt = 1'b1;
          end else if (progWord == `CLTD_OP_SWRST) begin
            nxt_soft = 1'b1;
          end else if (isTblRd || isTblWt) begin
            nxt_taddr = (progWord[1:0] == 2'h3) ? tptrInc : tptr_ff;
            nxt_tptr  = progWord[1:0] == 2'h2 ? tptrDec :
                        progWord[0] ? tptrInc : tptr_ff;
            nxt_trd    = isTblRd;
            nxt_twr    = isTblWt || tblBusy;
            nxt_twdata = isTblWt ? tlat_ff : tblWrData;
            nxt_state  = cltd_pkg::ST_FLUSH;
          end
          // Any other word, a stray 1111 word among them, is a no-op.
        end
      end
      cltd_pkg::ST_WORD2: begin
        // The second word is consumed whatever its contents.
        nxt_pc    = pcNext;
        nxt_state = cltd_pkg::ST_EXEC;
        if (word1_ff[11:9] == 3'h6) begin
          nxt_pc     = {word1_ff[7:0], progWord[11:0]};
          stkPush    = 1'b1;
          shadowSave = word1_ff[8];
        end else if (word1_ff[11:8] == `CLTD_N2_JMP) begin
          nxt_pc = {word1_ff[7:0], progWord[11:0]};
        end else if (word1_ff[5:4] != 2'h3) begin
          nxt_ptr[word1_ff[5:4]] = {word1_ff[3:0], progWord[7:0]};
        end
      end
      cltd_pkg::ST_FLUSH: begin
        nxt_state = cltd_pkg::ST_EXEC;
        if (tblRdStb) begin
          nxt_tlat = tblRdData;
        end
      end
      cltd_pkg::ST_SLEEP: begin
        if (wakeEvt) begin
          nxt_state = cltd_pkg::ST_EXEC;
        end
      end
      default: nxt_state = cltd_pkg::ST_EXEC;
    endcase
    // A register-port write wins over the core in the same cycle.
    if (regWrStb) begin
      case (regAddr)
        `CLTD_REG_CTRL: begin
          nxt_run  = regWrData[`CLTD_CTRL_RUN];
          nxt_gie  = regWrData[`CLTD_CTRL_GIE];
          nxt_peie = regWrData[`CLTD_CTRL_PEIE];
        end
        `CLTD_REG_WORK: begin
          nxt_w   = regWrData[7:0];
          nxt_bsr = regWrData[11:8];
        end
        `CLTD_REG_TPTR: nxt_tptr = regWrData[20:0];
        `CLTD_REG_TLAT: nxt_tlat = regWrData[7:0];
        default: nxt_run = nxt_run;
      endcase
    end
  end

  // Read-back multiplexer; unmapped indices read as zero.
  assign rdMux =
    regAddr == `CLTD_REG_CTRL   ? {29'h0, peie_ff, gie_ff, run_ff} :
    regAddr == `CLTD_REG_STATUS ? {21'h0, state_ff, to_ff, pd_ff,
                                   flags_ff} :
    regAddr == `CLTD_REG_WORK   ? {20'h0, bsr_ff, w_ff} :
    regAddr == `CLTD_REG_PC     ? {12'h0, pc_ff} :
    regAddr == `CLTD_REG_TPTR   ? {11'h0, tptr_ff} :
    regAddr == `CLTD_REG_TLAT   ? {24'h0, tlat_ff} :
    regAddr == `CLTD_REG_PROD   ? {16'h0, prod_ff} :
    regAddr == `CLTD_REG_PTR0   ? {20'h0, ptr_ff[0]} :
    regAddr == `CLTD_REG_PTR1   ? {20'h0, ptr_ff[1]} :
    regAddr == `CLTD_REG_PTR2   ? {20'h0, ptr_ff[2]} : 32'h0;

  // Architectural state; software reset clears it like a hard reset.
  always_ff @(posedge core_clk) begin
    if (coreReset) begin
      state_ff <= cltd_pkg::ST_EXEC;
      pc_ff    <= `CLTD_PC_RST;
      w_ff     <= `CLTD_W_RST;
      bsr_ff   <= 4'h0;
      flags_ff <= `CLTD_FLAG_RST;
      to_ff    <= 1'b1;
      pd_ff    <= 1'b1;
      word1_ff <= 16'h0000;
      prod_ff  <= 16'h0000;
      tptr_ff  <= 21'h000000;
      tlat_ff  <= 8'h00;
      sp_ff    <= 5'h00;
      gie_ff   <= 1'b0;
      peie_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      w_ff     <= nxt_w;
      bsr_ff   <= nxt_bsr;
      flags_ff <= nxt_flags;
      to_ff    <= nxt_to;
      pd_ff    <= nxt_pd;
      word1_ff <= nxt_word1;
      prod_ff  <= nxt_prod;
      tptr_ff  <= nxt_tptr;
      tlat_ff  <= nxt_tlat;
      gie_ff   <= nxt_gie;
      peie_ff  <= nxt_peie;
      sp_ff    <= nxt_sp + ((stkPush && sp_ff != `CLTD_SP_FULL) ? 5'h01 :
                  (stkPop && sp_ff != 5'h00) ? 5'h1f : 5'h00);
    end
  end

  // Pointers, one per indirect channel.
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge core_clk) begin
      ptr_ff[i] <= coreReset ? 12'h000 : nxt_ptr[i];
    end
  end

  // Stack storage and shadow context hold no reset; only sp is control.
  always_ff @(posedge core_clk) begin
    if (stkPush && sp_ff != `CLTD_SP_FULL) begin
      stack_ff[sp_ff] <= stkVal;
    end
    if (shadowSave) begin
      shadow_ff <= {flags_ff[4:2], bsr_ff, w_ff};
    end
  end

  // Outputs. The write request is cleared only by a hard reset so that a
  // software reset cannot cut an internal write short.
  always_ff @(posedge core_clk) begin
    tblWrReq  <= reset ? 1'b0 : nxt_twr;
    tblWrData <= reset ? 8'h00 : nxt_twdata;
    tblAddr   <= reset ? 21'h000000 : nxt_taddr;
    softReset <= reset ? 1'b0 : nxt_soft;
    run_ff    <= reset ? 1'b0 : nxt_run;
    tblRdStb  <= coreReset ? 1'b0 : nxt_trd;
    wdtClear  <= coreReset ? 1'b0 : nxt_wdt;
    sleepMode <= !coreReset && (nxt_state == cltd_pkg::ST_SLEEP);
    gieOut    <= !coreReset && nxt_gie;
    peieOut   <= !coreReset && nxt_peie;
    progAddr  <= coreReset ? `CLTD_PC_RST : nxt_pc;
    regRdData <= (reset || !regRdStb) ? 32'h0 : rdMux;
  end
endmodule

// ==== sim/cltd_monitor.sv ====
// Port checker for the instruction core, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cltd_monitor (
  input wire logic        core_clk,  // Core clock.
  input wire logic        reset,     // Synchronous reset.
  input wire logic [19:0] progAddr,  // Program address.
  input wire logic [20:0] tblAddr,   // Table address.
  input wire logic        tblRdStb,  // Table read strobe.
  input wire logic        tblWrReq,  // Table write busy.
  input wire logic [7:0]  tblWrData, // Table write data.
  input wire logic        tblWrDone, // Table write finished.
  input wire logic        wdtClear,  // Watchdog clear pulse.
  input wire logic [3:0]  regAddr,   // Register index.
  input wire logic        regRdStb,  // Register read strobe.
  input wire logic [31:0] regRdData  // Register read data.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // An in-flight write must not be dropped by later instruction flow.
  a_write_holds: assert property (
    tblWrReq && !tblWrDone |=> tblWrReq)
    else $error("table write dropped early");
  a_write_ends: assert property (
    tblWrReq && tblWrDone |=> !tblWrReq)
    else $error("table write outlived done");
  a_write_data: assert property (
    tblWrReq && $past(tblWrReq) |-> $stable(tblWrData))
    else $error("table write data moved");
  a_write_addr: assert property (
    tblWrReq && $past(tblWrReq) |-> $stable(tblAddr))
    else $error("table write address moved");
  a_read_pulse: assert property (tblRdStb |=> !tblRdStb)
    else $error("table read strobe too long");
  a_wdt_pulse: assert property (wdtClear |=> !wdtClear)
    else $error("watchdog clear too long");
  a_reset_pc: assert property (
    $fell(reset) |-> progAddr == 20'h0 && !tblWrReq)
    else $error("state not cleared by reset");
  a_pc_width: assert property (
    regRdStb && regAddr == 4'h3 |=> regRdData[31:20] == 12'h0)
    else $error("program counter read too wide");
  a_read_idle: assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data outside its cycle");
  c_write: cover property (tblWrReq && tblWrDone);
  c_read: cover property (tblRdStb);
  c_wdt: cover property (wdtClear);
endmodule
bind cltd_core cltd_monitor u_cltd_monitor (.core_clk(core_clk), .reset(reset),
  .progAddr(progAddr), .tblAddr(tblAddr), .tblRdStb(tblRdStb),
  .tblWrReq(tblWrReq), .tblWrData(tblWrData), .tblWrDone(tblWrDone),
  .wdtClear(wdtClear), .regAddr(regAddr), .regRdStb(regRdStb),
  .regRdData(regRdData));

// ==== sim/cltd_prog_mem.sv ====
// Program and table memory model facing the core.
// Assumes the bench loads the four program words before each run.
`timescale 1ns/1ps
module cltd_prog_mem (
  input  wire logic        core_clk,  // Core clock.
  input  wire logic        reset,     // Synchronous reset.
  input  wire logic [19:0] progAddr,  // Program address.
  output logic      [15:0] progWord,  // Word at that address.
  input  wire logic [20:0] tblAddr,   // Table address.
  input  wire logic        tblRdStb,  // Table read strobe.
  output logic      [7:0]  tblRdData, // Table read data.
  input  wire logic        tblWrReq,  // Table write busy.
  output logic             tblWrDone  // Table write finished.
);
  logic [15:0] rom [0:3];
  logic [1:0]  waitCnt_ff;
  // Addresses alias onto four words; data is inverted off the strobe so
  // a core that samples late sees a wrong value.
  assign progWord  = rom[progAddr[1:0]];
  assign tblRdData = tblRdStb ? tblAddr[7:0] : ~tblAddr[7:0];
  assign tblWrDone = tblWrReq && waitCnt_ff == 2'h3;
  // A slow write: done comes only in the fourth busy cycle.
  always_ff @(posedge core_clk) begin
    if (reset || !tblWrReq || tblWrDone) waitCnt_ff <= 2'h0;
    else waitCnt_ff <= waitCnt_ff + 2'h1;
  end
endmodule

// ==== sim/control_literal_table_decoder_tb.sv ====
// Self-checking bench: each row runs a literal load, one opcode, a loop.
// Assumes the memory model and the bound checker compile beside it.
`timescale 1ns/1ps
module control_literal_table_decoder_tb;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        wakeEvt = 1'b0;
  wire  [19:0] progAddr;
  wire  [15:0] progWord;
  wire  [20:0] tblAddr;
  wire  [7:0]  tblRdData;
  wire  [7:0]  tblWrData;
  wire         tblRdStb;
  wire         tblWrReq;
  wire         tblWrDone;
  wire  [31:0] regRdData;
  int          numErrors = 0;
  int          checksDone = 0;
  int          cycles = 0;
  logic [31:0] v;
  logic [63:0] r;
  // Row: start value, opcode, next word, {bank,work}, status, pc.
  localparam logic [63:0] ROWS [23] = '{
    64'h100f15d7ff025602, 64'hff0f01d7ff000672,
    64'h010801d7ff000672, 64'h010800d7ff0ff702,
    64'hf00b0fd7ff000642, 64'h010980d7ff081702,
    64'hff0affd7ff000642, 64'h000e80d7ff080602,
    64'h030d02d7ff003602, 64'h0f0007d7ff015602,
    64'h000105d7ff500602, 64'h00e001d7ff000602,
    64'h00e101d7ff000603, 64'h00e201d7ff000602,
    64'h00e301d7ff000603, 64'h00e401d7ff000602,
    64'h00e501d7ff000603, 64'h00e601d7ff000602,
    64'h00e701d7ff000603, 64'h00d801d7ff000603,
    64'h00ef00f003000603, 64'h00ee1af0bc000603,
    64'h00f123d7ff000602};
  localparam logic [15:0] OPS [5] = '{16'h0005, 16'h0006, 16'h0004,
                                      16'h0008, 16'h000c};
  cltd_core u_cltd_core (.core_clk(core_clk), .reset(reset),
    .progAddr(progAddr), .progWord(progWord), .tblAddr(tblAddr),
    .tblRdStb(tblRdStb), .tblRdData(tblRdData), .tblWrReq(tblWrReq),
    .tblWrData(tblWrData), .tblWrDone(tblWrDone), .wakeEvt(wakeEvt),
    .wdtClear(), .sleepMode(), .softReset(), .gieOut(), .peieOut(),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData));
  cltd_prog_mem u_cltd_prog_mem (.core_clk(core_clk), .reset(reset),
    .progAddr(progAddr), .progWord(progWord), .tblAddr(tblAddr),
    .tblRdStb(tblRdStb), .tblRdData(tblRdData), .tblWrReq(tblWrReq),
    .tblWrDone(tblWrDone));
  // Clock at 125 MHz.
  initial forever #4 core_clk = ~core_clk;
  // Each row needs about forty cycles, so this ceiling means a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      wrap_up();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk) regWrStb <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk) regRdStb <= 1'b0;
    #1 v = regRdData;
    @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    checksDone++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      numErrors++;
    end
  endtask
  // Fresh reset, program loaded, run a while, stop and inspect state.
  task automatic run_row(input logic [63:0] x);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    u_cltd_prog_mem.rom[0] = {8'h0e, x[63:56]};
    u_cltd_prog_mem.rom[1] = x[55:40];
    u_cltd_prog_mem.rom[2] = x[39:24];
    u_cltd_prog_mem.rom[3] = 16'hd7ff;
    reset <= 1'b0;
    wr(4'h0, 32'h1);
    repeat (30) @(posedge core_clk);
    wr(4'h0, 32'h0);
    rd(4'h2);
    chk("work", {20'h0, x[23:12]}, {20'h0, v[11:0]});
    rd(4'h1);
    chk("status", {25'h0, x[10:4]}, {25'h0, v[6:0]});
    rd(4'h3);
    chk("pc", {28'h0, x[3:0]}, v);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(4'h0);
    chk("ctrl", 32'h0, v);
    rd(4'h1);
    chk("status", 32'h60, {25'h0, v[6:0]});
    wr(4'hf, 32'hffffffff);
    rd(4'hf);
    chk("unmapped", 32'h0, v);
    $display("reset test done");
    foreach (ROWS[i]) begin
      run_row(ROWS[i]);
      $display("row %0d done", i);
    end
    // Stack, watchdog and table ops leave work and flags as they were.
    foreach (OPS[i]) begin
      r = {8'h07, OPS[i], 16'hd7ff, 12'h007, 8'h60, 4'h2};
      run_row(r);
      $display("op %h done", OPS[i]);
    end
    // Product and pointer land only in read-only registers.
    run_row(ROWS[8]);
    rd(4'h6);
    chk("prod", 32'h6, v);
    run_row(ROWS[21]);
    rd(4'h8);
    chk("ptr1", 32'habc, v);
    $display("result registers done");
    wrap_up();
  end
endmodule
